// ===== core/grlc_core.sv
// IEEE-488 instrument interface: handshakes, clear, remote/local, lockout
// What this block does
// - Full source and acceptor handshakes move multiline bytes reliably.
// - Talker sends data and answers a serial poll with the status byte.
// - Listener accepts bytes from the bus while addressed to listen.
// - Service request is raised at any time, independent of transfers.
// - Device trigger message requests one measurement trigger.
// - Device clear returns the instrument to its cleared initial state.
// - Interface clear resets the bus interface state.
// - Both universal and addressed (selected) clear are honoured.
// - Clear flushes output and input buffers and aborts running programs.
// - Clear empties status byte; bits 4-6 stay while their condition holds.
// - Clear blanks display, disables triggering until next device command.
// - Addressed go-to-local leaves remote; keyboard enabled unless locked.
// - After go-to-local, a device command or listen address restores remote.
// - Under lockout, go-to-local frees the keyboard only until next remote.
// - Remote-enable false returns local control and clears lockout.
// - Lockout keeps a local device local; a remote one loses its keys.
// - Lockout is cleared only by remote-enable false or reset.
// - Keyboard returns once the device is local and keyboard lock is gone; lockout does not hold it.
// - Remote state entered on own listen address with remote-enable true.
// - Poll byte weights: 16 ready, 32 error, 64 service requested.
`timescale 1ns/1ps
module grlc_core
	import grlc_pkg::*;
#(
	parameter int AXI_AW = 8
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire grlc_pin_in_t        bus_i,
	output grlc_pin_out_t            bus_o,
	output logic                     clear_pulse,
	output logic                     trig_pulse,
	output logic                     remote,
	output logic                     kbd_en,
	output logic                     local_key_en
);

	// Address decode needs the full low byte
	if (AXI_AW < 8) begin : gen_aw_check
		$error("AXI_AW must be at least 8");
	end

	function automatic logic fn_addr_hit(input logic [6:0] b, input logic [1:0] g,
		input logic [4:0] a);
		fn_addr_hit = (b[6:5] == g) && (b[4:0] == a);
	endfunction

	function automatic logic fn_is(input logic [7:0] a, input logic [7:0] ofs);
		fn_is = (a == ofs);
	endfunction

	// Pin synchroniser; only stage two is read
	grlc_pin_in_t sync1_r;
	grlc_pin_in_t sync2_r;
	always_ff @(posedge aclk) begin
		sync1_r <= bus_i;
		sync2_r <= sync1_r;
	end

	wire logic       atn_s  = !sync2_r.atn_n;
	wire logic       dav_s  = !sync2_r.dav_n;
	wire logic       ren_s  = !sync2_r.ren_n;
	wire logic       ifc_s  = !sync2_r.ifc_n;
	wire logic       nrfd_hi = sync2_r.nrfd_n;
	wire logic       ndac_hi = sync2_r.ndac_n;
	wire logic [7:0] dio_s  = ~sync2_r.dio_n;

	// Registers
	logic [5:0]  ctrl_r;
	logic [7:0]  stb_r;
	logic [2:0]  cond_r;
	logic [8:0]  tx_r;
	logic        tx_valid_r;
	logic [9:0]  rx_r;
	logic        rx_valid_r;
	logic        remote_r;
	logic        llo_r;
	logic        listen_r;
	logic        talk_r;
	logic        spe_r;
	logic        trig_en_r;
	logic        ifc_d_r;
	logic        clear_pulse_r;
	logic        trig_pulse_r;
	grlc_ah_t    ah_r;
	grlc_sh_t    sh_r;
	logic [15:0] settle_r;
	logic [7:0]  dio_out_r;
	logic        eoi_out_r;
	logic        sh_poll_r;
	logic        acc_pulse_r;
	logic [7:0]  acc_byte_r;
	logic        acc_atn_r;
	logic        acc_eoi_r;

	wire logic [4:0] my_addr  = ctrl_r[CTRL_ADDR_LSB +: 5];
	wire logic       kbd_lock = ctrl_r[CTRL_LOCK_BIT];

	// Acceptor handshake
	wire logic ah_active = atn_s || listen_r;
	wire logic ah_ready  = atn_s || !rx_valid_r;
	wire logic ah_take   = (ah_r == AH_RDY) && ah_ready && dav_s;

	always_ff @(posedge aclk) begin
		if (!aresetn || ifc_s) begin
			ah_r <= AH_IDLE;
		end else begin
			unique case (ah_r)
				AH_IDLE: if (ah_active) ah_r <= AH_RDY;
				AH_RDY: begin
					if (!ah_active) ah_r <= AH_IDLE;
					else if (ah_take) ah_r <= AH_ACC;
				end
				AH_ACC: if (!dav_s) ah_r <= AH_RDY;
			endcase
		end
	end

	// One-cycle message pulse with its byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_pulse_r <= 1'b0;
			acc_byte_r  <= 8'h00;
			acc_atn_r   <= 1'b0;
			acc_eoi_r   <= 1'b0;
		end else begin
			acc_pulse_r <= ah_take && !ifc_s;
			if (ah_take) begin
				acc_byte_r <= dio_s;
				acc_atn_r  <= atn_s;
				acc_eoi_r  <= !sync2_r.eoi_n;
			end
		end
	end

	// Message decode
	wire logic [6:0] cb      = acc_byte_r[6:0];
	wire logic       cmd_ok  = acc_pulse_r && acc_atn_r;
	wire logic       dat_ok  = acc_pulse_r && !acc_atn_r && listen_r;
	wire logic       hit_mla = cmd_ok && fn_addr_hit(cb, GRP_LISTEN, my_addr);
	wire logic       hit_mta = cmd_ok && fn_addr_hit(cb, GRP_TALK, my_addr);
	wire logic       hit_ota = cmd_ok && (cb[6:5] == GRP_TALK) && !hit_mta;
	wire logic       hit_unl = cmd_ok && (cb == CMD_UNL);
	wire logic       hit_gtl = cmd_ok && (cb == CMD_GTL) && listen_r;
	wire logic       hit_get = cmd_ok && (cb == CMD_GET) && listen_r;
	wire logic       hit_llo = cmd_ok && (cb == CMD_LLO);
	wire logic       hit_spe = cmd_ok && (cb == CMD_SPE);
	wire logic       hit_spd = cmd_ok && (cb == CMD_SPD);
	wire logic       hit_sdc = cmd_ok && (cb == CMD_SDC) && listen_r;
	wire logic       hit_dcl = cmd_ok && (cb == CMD_DCL);
	wire logic       clr_req = hit_dcl || hit_sdc;
	wire logic       ifc_pulse = ifc_s && !ifc_d_r;

	// Addressing and poll state; interface clear drops it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ifc_d_r  <= 1'b0;
			listen_r <= 1'b0;
			talk_r   <= 1'b0;
			spe_r    <= 1'b0;
		end else begin
			ifc_d_r <= ifc_s;
			if (ifc_s) begin
				listen_r <= 1'b0;
				talk_r   <= 1'b0;
				spe_r    <= 1'b0;
			end else begin
				if (hit_mla) listen_r <= 1'b1;
				else if (hit_unl) listen_r <= 1'b0;
				if (hit_mta) talk_r <= 1'b1;
				else if (hit_ota || (cmd_ok && cb == CMD_UNT)) talk_r <= 1'b0;
				if (hit_spe) spe_r <= 1'b1;
				else if (hit_spd) spe_r <= 1'b0;
			end
		end
	end

	// Remote, lockout, trigger enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remote_r  <= 1'b0;
			llo_r     <= 1'b0;
			trig_en_r <= 1'b1;
		end else begin
			if (!ren_s) begin
				remote_r <= 1'b0;
				llo_r    <= 1'b0;
			end else begin
				if (hit_gtl) remote_r <= 1'b0;
				else if (hit_mla || dat_ok) remote_r <= 1'b1;
				if (hit_llo) llo_r <= 1'b1;
			end
			if (clr_req) trig_en_r <= 1'b0;
			else if (dat_ok) trig_en_r <= 1'b1;
		end
	end

	// Remote state or the keyboard lock bit locks the keys, lockout does not, so lockout plus go-to-local frees them
	assign remote       = remote_r;
	assign kbd_en       = !remote_r && !kbd_lock;
	assign local_key_en = !llo_r && !kbd_lock && remote_r;

	// Source handshake
	wire logic sh_active = talk_r && !atn_s;
	wire logic sh_go     = sh_active && (spe_r || tx_valid_r);
	wire logic sh_done   = (sh_r == SH_DAV) && ndac_hi && sh_active;

	always_ff @(posedge aclk) begin
		if (!aresetn || ifc_s) begin
			sh_r      <= SH_IDLE;
			settle_r  <= 16'h0000;
			dio_out_r <= 8'h00;
			eoi_out_r <= 1'b0;
			sh_poll_r <= 1'b0;
		end else begin
			unique case (sh_r)
				SH_IDLE: if (sh_go) begin
					sh_r      <= SH_SETTLE;
					settle_r  <= 16'h0000;
					sh_poll_r <= spe_r;
					dio_out_r <= spe_r ? stb_r : tx_r[7:0];
					eoi_out_r <= !spe_r && tx_r[TX_EOI_BIT];
				end
				SH_SETTLE: begin
					if (!sh_active) sh_r <= SH_IDLE;
					else if (settle_r >= 16'(SETTLE_CYC) && nrfd_hi) sh_r <= SH_DAV;
					else if (settle_r < 16'(SETTLE_CYC)) settle_r <= settle_r + 16'h0001;
				end
				SH_DAV: if (!sh_active || ndac_hi) sh_r <= SH_IDLE;
			endcase
		end
	end

	wire logic talk_drv = sh_active && (sh_r != SH_IDLE);

	assign bus_o.dio_n_out  = ~dio_out_r;
	assign bus_o.dio_oe     = talk_drv;
	assign bus_o.dav_n_out  = 1'b0;
	assign bus_o.dav_oe     = sh_active && (sh_r == SH_DAV);
	assign bus_o.eoi_n_out  = 1'b0;
	assign bus_o.eoi_oe     = talk_drv && eoi_out_r;
	assign bus_o.nrfd_n_out = 1'b0;
	assign bus_o.nrfd_oe    = (ah_r == AH_ACC) || ((ah_r == AH_RDY) && !ah_ready);
	assign bus_o.ndac_n_out = 1'b0;
	assign bus_o.ndac_oe    = (ah_r == AH_RDY);
	assign bus_o.srq_n_out  = 1'b0;
	assign bus_o.srq_oe     = stb_r[STB_RQS];

	// AXI4-Lite slave
	logic              aw_hold_r;
	logic              w_hold_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;

	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	wire logic              aw_hs  = s_axi_awvalid && s_axi_awready;
	wire logic              w_hs   = s_axi_wvalid && s_axi_wready;
	wire logic              ar_hs  = s_axi_arvalid && s_axi_arready;
	wire logic              wr_go  = (aw_hold_r || aw_hs) && (w_hold_r || w_hs);
	wire logic [AXI_AW-1:0] wa     = aw_hold_r ? awaddr_r : s_axi_awaddr;
	wire logic [31:0]       wd     = w_hold_r ? wdata_r : s_axi_wdata;
	wire logic [7:0]        wa8    = wa[7:0];
	wire logic [7:0]        ra8    = s_axi_araddr[7:0];
	wire logic              wa_hi  = (wa >> 8) != '0;
	wire logic              ra_hi  = (s_axi_araddr >> 8) != '0;
	wire logic              wr_lo  = wr_go && s_axi_wstrb[0] && !wa_hi;
	wire logic              wr_ctl = wr_lo && fn_is(wa8, OFS_CTRL);
	wire logic              wr_stb = wr_lo && fn_is(wa8, OFS_STB);
	wire logic              wr_cnd = wr_lo && fn_is(wa8, OFS_COND);
	wire logic              wr_tx  = wr_go && (&s_axi_wstrb[1:0]) && !wa_hi && fn_is(wa8, OFS_TX);
	wire logic              wr_map = !wa_hi && (fn_is(wa8, OFS_CTRL) || fn_is(wa8, OFS_STB)
		|| fn_is(wa8, OFS_COND) || fn_is(wa8, OFS_TX) || fn_is(wa8, OFS_STAT)
		|| fn_is(wa8, OFS_RX));
	wire logic              rd_rx  = ar_hs && !ra_hi && fn_is(ra8, OFS_RX);

	wire logic [31:0] stat_w = {24'h000000, rx_valid_r, tx_valid_r, trig_en_r, spe_r,
		talk_r, listen_r, llo_r, remote_r};
	wire logic        rd_map = !ra_hi && (fn_is(ra8, OFS_CTRL) || fn_is(ra8, OFS_STAT)
		|| fn_is(ra8, OFS_STB) || fn_is(ra8, OFS_COND) || fn_is(ra8, OFS_TX)
		|| fn_is(ra8, OFS_RX));
	wire logic [31:0] rd_mux =
		ra_hi ? 32'h00000000 :
		fn_is(ra8, OFS_CTRL) ? {26'h0000000, ctrl_r} :
		fn_is(ra8, OFS_STAT) ? stat_w :
		fn_is(ra8, OFS_STB)  ? {24'h000000, stb_r} :
		fn_is(ra8, OFS_COND) ? {29'h00000000, cond_r} :
		fn_is(ra8, OFS_RX)   ? {22'h000000, rx_r[RX_EOI_BIT], rx_valid_r, rx_r[7:0]} :
		32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h00000000;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else begin
				if (aw_hs) aw_hold_r <= 1'b1;
				if (w_hs) w_hold_r <= 1'b1;
				if (bvalid_r && s_axi_bready) bvalid_r <= 1'b0;
			end
			if (aw_hs) awaddr_r <= s_axi_awaddr;
			if (w_hs) wdata_r <= s_axi_wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Status byte: clear keeps only bits whose condition persists
	wire logic [7:0] stb_keep = {1'b0, cond_r, 4'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RST;
			cond_r <= COND_RST;
			stb_r  <= STB_RST;
		end else begin
			if (wr_ctl) ctrl_r <= wd[5:0];
			if (wr_cnd) cond_r <= wd[2:0];
			if (clr_req) stb_r <= stb_r & stb_keep;
			else if (wr_stb) stb_r <= wd[7:0];
			else if (sh_done && sh_poll_r && !cond_r[STB_RQS-4])
				stb_r[STB_RQS] <= 1'b0;
		end
	end

	// Buffers; a clear flushes both and wins over a same-cycle write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_r       <= 9'h000;
			tx_valid_r <= 1'b0;
			rx_r       <= 10'h000;
			rx_valid_r <= 1'b0;
		end else begin
			if (clr_req) tx_valid_r <= 1'b0;
			else if (wr_tx) tx_valid_r <= 1'b1;
			else if (sh_done && !sh_poll_r) tx_valid_r <= 1'b0;
			if (wr_tx) tx_r <= wd[8:0];
			if (clr_req) rx_valid_r <= 1'b0;
			else if (dat_ok) rx_valid_r <= 1'b1;
			else if (rd_rx) rx_valid_r <= 1'b0;
			if (dat_ok) rx_r <= {acc_eoi_r, 1'b0, acc_byte_r};
		end
	end

	// Clear pulse drives flush, program abort and display blank downstream
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clear_pulse_r <= 1'b0;
			trig_pulse_r  <= 1'b0;
		end else begin
			clear_pulse_r <= clr_req;
			trig_pulse_r  <= hit_get && trig_en_r;
		end
	end

	assign clear_pulse = clear_pulse_r;
	assign trig_pulse  = trig_pulse_r;

	a_ren_drop_local: assert property (@(posedge aclk) disable iff (!aresetn)
		!ren_s |=> !remote_r && !llo_r) else $error("remote kept with ren false");
	a_llo_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		llo_r && ren_s |=> llo_r) else $error("lockout dropped");
	a_mla_remote: assert property (@(posedge aclk) disable iff (!aresetn)
		hit_mla && ren_s |=> remote_r) else $error("listen address no remote");
	a_gtl_local: assert property (@(posedge aclk) disable iff (!aresetn)
		hit_gtl |=> !remote_r && (kbd_en == !kbd_lock)) else $error("gtl failed");
	a_clear_flush: assert property (@(posedge aclk) disable iff (!aresetn)
		clr_req |=> !rx_valid_r && !tx_valid_r && !trig_en_r && clear_pulse)
		else $error("clear did not flush");
	a_clear_stb: assert property (@(posedge aclk) disable iff (!aresetn)
		clr_req |=> stb_r == ($past(stb_r) & $past(stb_keep))) else $error("stb clear");
	a_ifc_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		ifc_pulse |=> !listen_r && !talk_r && ah_r == AH_IDLE) else $error("ifc");
	a_dav_ready: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(bus_o.dav_oe) |-> $past(nrfd_hi) && $past(settle_r) >= 16'(SETTLE_CYC))
		else $error("dav before ready");
	a_get_trig: assert property (@(posedge aclk) disable iff (!aresetn)
		hit_get && trig_en_r |=> trig_pulse ##1 !trig_pulse) else $error("get");
	a_kbd_remote: assert property (@(posedge aclk) disable iff (!aresetn)
		llo_r && ren_s && (hit_mla || dat_ok) |=> !kbd_en && !local_key_en)
		else $error("keys live after remote command");
	a_acc_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_pulse_r |=> !acc_pulse_r) else $error("pulse too long");

	c_poll: cover property (@(posedge aclk) disable iff (!aresetn) sh_done && sh_poll_r);
	c_clear: cover property (@(posedge aclk) disable iff (!aresetn) hit_dcl ##[1:200] hit_sdc);
	c_llo_gtl: cover property (@(posedge aclk) disable iff (!aresetn)
		llo_r && hit_gtl ##[1:200] dat_ok);
	c_data: cover property (@(posedge aclk) disable iff (!aresetn) sh_done && !sh_poll_r);

endmodule

// ===== include/grlc_pkg.sv
// Constants, types and pin bundles for the IEEE-488 remote/local/clear block
package grlc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_STB  = 8'h08;
	localparam logic [7:0] OFS_COND = 8'h0C;
	localparam logic [7:0] OFS_TX   = 8'h10;
	localparam logic [7:0] OFS_RX   = 8'h14;

	// Control register fields and reset value
	localparam int         CTRL_ADDR_LSB = 0;
	localparam int         CTRL_LOCK_BIT = 5;
	localparam logic [5:0] CTRL_RST      = 6'h16;

	// Status register field positions
	localparam int STAT_REMOTE = 0;
	localparam int STAT_LLO    = 1;
	localparam int STAT_LISTEN = 2;
	localparam int STAT_TALK   = 3;
	localparam int STAT_SPE    = 4;
	localparam int STAT_TRIGEN = 5;
	localparam int STAT_TXV    = 6;
	localparam int STAT_RXV    = 7;

	// Data register fields
	localparam int TX_EOI_BIT = 8;
	localparam int RX_VAL_BIT = 8;
	localparam int RX_EOI_BIT = 9;

	// Status byte bits with persisting conditions
	localparam int         STB_READY = 4;
	localparam int         STB_ERR   = 5;
	localparam int         STB_RQS   = 6;
	localparam logic [7:0] STB_RST   = 8'h00;
	localparam logic [2:0] COND_RST  = 3'h0;

	// Interface messages, seven bits, sent with attention true
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam logic [6:0] CMD_UNT = 7'h5F;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;

	// Data settling time before the data-valid strobe
	localparam int CLK_NS      = 10;
	localparam int T_SETTLE_NS = 2000;
	localparam int SETTLE_CYC  = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Bus lines as seen at the pins, all active low
	typedef struct packed {
		logic [7:0] dio_n;
		logic       dav_n;
		logic       nrfd_n;
		logic       ndac_n;
		logic       atn_n;
		logic       ifc_n;
		logic       ren_n;
		logic       eoi_n;
	} grlc_pin_in_t;

	// Drive side; open-drain lines pull low while their enable is high
	typedef struct packed {
		logic [7:0] dio_n_out;
		logic       dio_oe;
		logic       dav_n_out;
		logic       dav_oe;
		logic       eoi_n_out;
		logic       eoi_oe;
		logic       nrfd_n_out;
		logic       nrfd_oe;
		logic       ndac_n_out;
		logic       ndac_oe;
		logic       srq_n_out;
		logic       srq_oe;
	} grlc_pin_out_t;

	typedef enum logic [1:0] {AH_IDLE, AH_RDY, AH_ACC} grlc_ah_t;
	typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV} grlc_sh_t;

endpackage

// ===== verification/gpib_remote_local_clear_tb_top.sv
// Self-checking bench for the remote/local/clear block
`timescale 1ns/1ps
module gpib_remote_local_clear_tb_top;
	import grlc_pkg::*;
	logic          aclk    = 1'b0;
	logic          aresetn = 1'b0;
	logic [7:0]    awaddr  = 8'h00;
	logic [7:0]    araddr  = 8'h00;
	logic [31:0]   wdata   = 32'h0;
	logic          awvalid = 1'b0;
	logic          wvalid  = 1'b0;
	logic          bready  = 1'b0;
	logic          arvalid = 1'b0;
	logic          rready  = 1'b0;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp, rr, br;
	logic [31:0]   rdata, rd, s, c;
	logic [8:0]    tk;
	logic          clr, trg, remote, kbd, lke;
	grlc_pin_in_t  bi;
	grlc_pin_out_t bo;
	int            errors = 0;
	int            samples_checked = 0;
	int            nclr = 0;
	int            ntrg = 0;
	int            k;
	int            seed = 32'h90015D8F;

	grlc_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus_i(bi), .bus_o(bo), .clear_pulse(clr),
		.trig_pulse(trg), .remote(remote), .kbd_en(kbd), .local_key_en(lke));
	grlc_ctl_model M (.dev_o(bo), .aclk(aclk), .dev_i(bi));

	initial begin
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (clr === 1'b1) nclr++;
		if (trg === 1'b1) ntrg++;
	end

	task finish_test;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		br = bresp;
		bready <= 1'b0;
		if (n == 100) begin
			errors++;
			finish_test;
		end
	endtask
	task axr(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
		if (n == 100) begin
			errors++;
			finish_test;
		end
	endtask
	// Message effects land a few cycles after the handshake closes
	task msg(input logic [7:0] b, input logic atn);
		M.slow = 1 + ($random(seed) & 7);
		M.send(b, atn);
		repeat (6) @(posedge aclk);
	endtask
	function automatic logic [31:0] exp_stb(input logic [31:0] sb, input logic [31:0] cd);
		return sb & {24'h0, 1'b0, cd[2:0], 4'h0};
	endfunction

	initial begin
		repeat (100000) @(posedge aclk);
		errors++;
		finish_test;
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axr(OFS_CTRL);
		chk(rd, 32'h16);
		axr(8'h3C);
		chk(rr, RESP_SLVERR);
		M.ren_n_r <= 1'b0;
		repeat (8) @(posedge aclk);
		chk(remote, 1'b0);
		msg(8'h36, 1'b1);
		chk({remote, lke}, 2'b11);
		msg(CMD_LLO, 1'b1);
		chk({remote, lke, kbd}, 3'b100);
		msg(CMD_GTL, 1'b1);
		chk({remote, kbd}, 2'b01);
		msg(8'h41, 1'b0);
		chk({remote, kbd}, 2'b10);
		axr(OFS_RX);
		chk(rd[9:0], 10'h141);
		for (int i = 0; i < 4; i++) begin
			s = $random(seed);
			c = $random(seed);
			axw(OFS_STB, {24'h0, s[7:0]});
			chk(bo.srq_oe, s[6]);
			axw(OFS_COND, {29'h0, c[2:0]});
			k = nclr;
			msg(i[0] ? CMD_DCL : CMD_SDC, 1'b1);
			chk(nclr - k, 1);
			axr(OFS_STB);
			chk(rd, exp_stb({24'h0, s[7:0]}, c));
		end
		k = ntrg;
		msg(CMD_GET, 1'b1);
		chk(ntrg - k, 0);
		msg(8'h52, 1'b0);
		axr(OFS_RX);
		msg(CMD_GET, 1'b1);
		chk(ntrg - k, 1);
		axw(OFS_CTRL, 32'h36);
		msg(CMD_GTL, 1'b1);
		chk({remote, kbd}, 2'b00);
		axw(OFS_CTRL, 32'h16);
		chk(kbd, 1'b1);
		M.ren_n_r <= 1'b1;
		msg(8'h36, 1'b1);
		chk({remote, kbd}, 2'b01);
		M.ren_n_r <= 1'b0;
		msg(8'h36, 1'b1);
		chk({remote, lke}, 2'b11);
		M.ifc_n_r <= 1'b0;
		repeat (4) @(posedge aclk);
		M.ifc_n_r <= 1'b1;
		axr(OFS_STAT);
		chk(rd[STAT_LISTEN], 1'b0);
		// Serial poll: byte 0x50 out, service bit drops since its condition is off
		axw(OFS_STB, 32'h50);
		chk(br, RESP_OKAY);
		axw(OFS_COND, 32'h0);
		msg(CMD_SPE, 1'b1);
		msg(8'h56, 1'b1);
		M.take(tk);
		chk(tk, 9'h050);
		axr(OFS_STB);
		chk({rd[7:0], bo.srq_oe}, 9'h020);
		msg(CMD_SPD, 1'b1);
		axw(OFS_TX, 32'h1A5);
		M.take(tk);
		chk(tk, 9'h1A5);
		axw(8'h3C, 32'h0);
		chk(br, RESP_SLVERR);
		chk(M.tmo, 0);
		finish_test;
	end
endmodule

// ===== verification/grlc_ctl_model.sv
// Bus controller model: sends interface messages and data bytes
`timescale 1ns/1ps
module grlc_ctl_model
	import grlc_pkg::*;
(
	input  wire grlc_pin_out_t dev_o,
	input  wire logic          aclk,
	output grlc_pin_in_t       dev_i
);
	logic [7:0] byte_r  = 8'h00;
	logic       drv_r   = 1'b0;
	logic       dav_n_r = 1'b1;
	logic       atn_n_r = 1'b1;
	logic       ifc_n_r = 1'b1;
	logic       ren_n_r = 1'b1;
	logic       ndac_n_r = 1'b1;
	int         slow    = 1;
	int         tmo     = 0;
	// Released lines float to the pull-up level
	assign dev_i.dio_n  = drv_r ? ~byte_r : (dev_o.dio_oe ? dev_o.dio_n_out : 8'hFF);
	assign dev_i.dav_n  = dav_n_r & ~dev_o.dav_oe;
	assign dev_i.nrfd_n = ~dev_o.nrfd_oe;
	assign dev_i.ndac_n = ndac_n_r & ~dev_o.ndac_oe;
	assign dev_i.eoi_n  = ~dev_o.eoi_oe;
	assign dev_i.atn_n  = atn_n_r;
	assign dev_i.ifc_n  = ifc_n_r;
	assign dev_i.ren_n  = ren_n_r;
	// One byte, universal or addressed; waits only for the acceptor
	task send(input logic [7:0] b, input logic atn);
		int n;
		@(posedge aclk);
		atn_n_r <= ~atn;
		for (n = 0; n < 500 && !(dev_i.nrfd_n === 1'b1 && dev_i.ndac_n === 1'b0); n++) begin
			@(posedge aclk);
		end
		byte_r <= b;
		drv_r  <= 1'b1;
		repeat (slow) @(posedge aclk);
		dav_n_r <= 1'b0;
		for (n = n; n < 1000 && dev_i.ndac_n !== 1'b1; n++) begin
			@(posedge aclk);
		end
		dav_n_r <= 1'b1;
		@(posedge aclk);
		drv_r <= 1'b0;
		if (n >= 1000) tmo++;
	endtask
	// Listener side of a talk transfer; returns {eoi, byte}
	task take(output logic [8:0] b);
		int n;
		@(posedge aclk);
		atn_n_r  <= 1'b1;
		ndac_n_r <= 1'b0;
		for (n = 0; n < 1000 && dev_i.dav_n !== 1'b0; n++) begin
			@(posedge aclk);
		end
		b = {~dev_i.eoi_n, ~dev_i.dio_n};
		ndac_n_r <= 1'b1;
		for (n = n; n < 2000 && dev_i.dav_n !== 1'b1; n++) begin
			@(posedge aclk);
		end
		if (n >= 1000) tmo++;
	endtask
endmodule
